// >>> hdl/sbf_pkg.sv
/*
 * Shared constants and types for the serial bridge and its target end.
 * Assumes a single 50 MHz clock on both ends; each end keeps its own bit timing.
 */
package sbf_pkg;
    localparam int CLK_HZ       = 50_000_000;
    localparam int BAUD_DEFAULT = 115200;
    localparam int BAUD_MIN     = 9600;
    localparam int BAUD_MAX     = 921600;
    localparam int DATA_BITS    = 8;
    localparam int BUF_DEPTH    = 2;
    localparam int DIV_W        = 13;

    // Clocks per bit; rates outside the supported span are clamped
    localparam logic [DIV_W-1:0] DIV_DEFAULT = DIV_W'(CLK_HZ / BAUD_DEFAULT);
    localparam logic [DIV_W-1:0] DIV_MIN     = DIV_W'(CLK_HZ / BAUD_MAX);
    localparam logic [DIV_W-1:0] DIV_MAX     = DIV_W'(CLK_HZ / BAUD_MIN);

    localparam logic LINE_IDLE  = 1'h1;
    localparam logic HS_READY_N = 1'h0;
    localparam logic HS_HOLD_N  = 1'h1;
    localparam logic LINK_EN_RESET = 1'h1;
    localparam logic HS_EN_RESET   = 1'h0;

    typedef enum logic [1:0] {
        SBF_HS_DISABLED,
        SBF_HS_RTS,
        SBF_HS_CTS,
        SBF_HS_RTSCTS
    } sbf_hs_mode_t;

    localparam sbf_hs_mode_t HS_MODE_RESET = SBF_HS_DISABLED;

    function automatic logic [DIV_W-1:0] sbf_clamp_div(input logic [DIV_W-1:0] d);
        logic [DIV_W-1:0] r;
        r = d;
        if (d < DIV_MIN) begin
            r = DIV_MIN;
        end else if (d > DIV_MAX) begin
            r = DIV_MAX;
        end
        return r;
    endfunction
endpackage

// >>> hdl/sbf_link_if.sv
/*
 * Serial link between the bridge and the target: data lines, handshakes, enable.
 * Assumes the bench joins both ends; an undriven clear-to-send line is pulled low.
 */
interface sbf_link_if;
    logic tgt_tx;
    logic tgt_rx;
    logic cts_n_drv;
    logic cts_n_oe;
    logic cts_n;
    logic rts_n;
    logic link_en;

    localparam logic HS_READY_N_LVL = 1'h0;

    // Pull-down: an undriven clear-to-send reads as ready
    assign cts_n = cts_n_oe ? cts_n_drv : HS_READY_N_LVL;

    modport bridge (input tgt_tx, input rts_n, input link_en, output tgt_rx, output cts_n_drv, output cts_n_oe);
    modport target (output tgt_tx, output rts_n, output link_en, input tgt_rx, input cts_n);
endinterface

// >>> hdl/sbf_bridge.sv
/*
 * Bridge end: UART shifters, a small buffer, handshake modes and host routing.
 * Assumes link pins arrive asynchronously; buffer module comes with the target end.
 */
// Function
// - Reset gives 115200 8N1, handshake off
// - Bit rate settable from 9600 to 921600
// - Target sends on tx, bridge on rx
// - Clear-to-send held off while buffer full
// - Target stops sending while clear-to-send off
// - Target asserts request-to-send when it can receive
// - Bridge pauses while request-to-send deasserted
// - Character in flight always finishes
// - Target accepts one more after deasserting
// - Disabled mode: no drive, input ignored
// - Output mode: drive clear-to-send, ignore input
// - Input mode: no drive, gate on request
// - Combined mode: drive and gate both
// - Data passes only while enable high
// - Connected socket silences the USB channel

module sbf_uart_tx import sbf_pkg::*; (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [DIV_W-1:0] bit_cycles,
    input  wire logic             start,
    input  wire logic [7:0]       data,
    output logic                  ready,
    output logic                  txd_q
);
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] cnt_q;
    logic [3:0]       bit_q;
    logic [8:0]       shift_q;
    logic             busy_q;

    assign ready = !busy_q;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            busy_q  <= 1'h0;
            txd_q   <= LINE_IDLE;
            div_q   <= DIV_DEFAULT;
            cnt_q   <= '0;
            bit_q   <= '0;
            shift_q <= '0;
        end else if (!busy_q) begin
            if (start) begin
                busy_q  <= 1'h1;
                txd_q   <= 1'h0;
                div_q   <= bit_cycles;
                cnt_q   <= bit_cycles - 1'h1;
                bit_q   <= '0;
                shift_q <= {LINE_IDLE, data};
            end
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'h1;
        end else begin
            cnt_q <= div_q - 1'h1;
            // Runs to the stop bit whatever the handshake does meanwhile
            if (bit_q == 4'(DATA_BITS + 1)) begin
                busy_q <= 1'h0;
            end else begin
                txd_q   <= shift_q[0];
                shift_q <= {LINE_IDLE, shift_q[8:1]};
                bit_q   <= bit_q + 1'h1;
            end
        end
    end
endmodule // sbf_uart_tx

module sbf_uart_rx import sbf_pkg::*; (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [DIV_W-1:0] bit_cycles,
    input  wire logic             rxd,
    output logic                  valid_q,
    output logic                  ferr_q,
    output logic [7:0]            data_q
);
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] cnt_q;
    logic [3:0]       bit_q;
    logic [7:0]       shift_q;
    logic             busy_q;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            busy_q  <= 1'h0;
            valid_q <= 1'h0;
            ferr_q  <= 1'h0;
            data_q  <= '0;
            div_q   <= DIV_DEFAULT;
            cnt_q   <= '0;
            bit_q   <= '0;
            shift_q <= '0;
        end else begin
            valid_q <= 1'h0;
            ferr_q  <= 1'h0;
            if (!busy_q) begin
                if (!rxd) begin
                    // Half a bit in, so every later sample lands mid-bit
                    busy_q <= 1'h1;
                    div_q  <= bit_cycles;
                    cnt_q  <= bit_cycles >> 1;
                    bit_q  <= '0;
                end
            end else if (cnt_q != '0) begin
                cnt_q <= cnt_q - 1'h1;
            end else begin
                cnt_q <= div_q - 1'h1;
                if (bit_q == '0) begin
                    busy_q <= !rxd; // Glitch shorter than half a bit dropped
                    bit_q  <= 4'h1;
                end else if (bit_q <= 4'(DATA_BITS)) begin
                    shift_q <= {rxd, shift_q[7:1]};
                    bit_q   <= bit_q + 1'h1;
                end else begin
                    busy_q  <= 1'h0;
                    valid_q <= rxd;
                    ferr_q  <= !rxd;
                    data_q  <= shift_q;
                end
            end
        end
    end
endmodule // sbf_uart_rx

module sbf_bridge import sbf_pkg::*; (
    input  wire logic             clock,
    input  wire logic             rst_n,
    sbf_link_if.bridge            link,
    input  wire logic             cfg_wr,
    input  wire sbf_hs_mode_t     cfg_mode,
    input  wire logic [DIV_W-1:0] cfg_bit_cycles,
    input  wire logic             sock_connected,
    input  wire logic             usb_in_valid,
    input  wire logic [7:0]       usb_in_data,
    output logic                  usb_in_ready,
    input  wire logic             sock_in_valid,
    input  wire logic [7:0]       sock_in_data,
    output logic                  sock_in_ready,
    output logic                  usb_out_valid,
    output logic [7:0]            usb_out_data,
    input  wire logic             usb_out_ready,
    output logic                  sock_out_valid,
    output logic [7:0]            sock_out_data,
    input  wire logic             sock_out_ready,
    output logic                  overrun_q,
    output logic                  frame_err_q
);
    sbf_hs_mode_t     mode_q;
    logic [DIV_W-1:0] div_q;
    logic             rx_s1, rx_s2, rts_s1, rts_s2, en_s1, en_s2;
    logic             cts_n_q;
    logic             drive_cts, gate_rts, tx_permit, tx_ready, tx_start;
    logic             rx_valid, rx_ferr, f_in_ready, f_valid, f_ready;
    logic [7:0]       rx_data, f_data, src_data;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            mode_q <= HS_MODE_RESET;
            div_q  <= DIV_DEFAULT;
        end else if (cfg_wr) begin
            mode_q <= cfg_mode;
            div_q  <= sbf_clamp_div(cfg_bit_cycles);
        end
    end

    // Pins come from the target's domain
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rx_s1  <= LINE_IDLE;
            rx_s2  <= LINE_IDLE;
            rts_s1 <= HS_HOLD_N;
            rts_s2 <= HS_HOLD_N;
            en_s1  <= 1'h0;
            en_s2  <= 1'h0;
        end else begin
            rx_s1  <= link.tgt_tx;
            rx_s2  <= rx_s1;
            rts_s1 <= link.rts_n;
            rts_s2 <= rts_s1;
            en_s1  <= link.link_en;
            en_s2  <= en_s1;
        end
    end

    assign drive_cts = (mode_q == SBF_HS_RTS) || (mode_q == SBF_HS_RTSCTS);
    assign gate_rts  = (mode_q == SBF_HS_CTS) || (mode_q == SBF_HS_RTSCTS);
    // Low request-to-send means the target can take more
    assign tx_permit = en_s2 && (!gate_rts || rts_s2 == HS_READY_N);

    // Socket wins; USB sees neither readiness nor data while it is up
    assign src_data      = sock_connected ? sock_in_data : usb_in_data;
    assign usb_in_ready  = !sock_connected && tx_ready && tx_permit;
    assign sock_in_ready = sock_connected && tx_ready && tx_permit;
    assign tx_start      = sock_connected ? sock_in_valid && sock_in_ready : usb_in_valid && usb_in_ready;

    sbf_uart_tx u_tx (
        .clock      (clock),
        .rst_n      (rst_n),
        .bit_cycles (div_q),
        .start      (tx_start),
        .data       (src_data),
        .ready      (tx_ready),
        .txd_q      (link.tgt_rx)
    );

    sbf_uart_rx u_rx (
        .clock      (clock),
        .rst_n      (rst_n),
        .bit_cycles (div_q),
        .rxd        (rx_s2),
        .valid_q    (rx_valid),
        .ferr_q     (rx_ferr),
        .data_q     (rx_data)
    );

    sbf_fifo #(.W(DATA_BITS), .DEPTH(BUF_DEPTH)) u_buf (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_valid  (rx_valid && en_s2),
        .in_data   (rx_data),
        .in_ready  (f_in_ready),
        .out_valid (f_valid),
        .out_data  (f_data),
        .out_ready (f_ready),
        .level     ()
    );

    assign usb_out_valid  = f_valid && !sock_connected;
    assign sock_out_valid = f_valid && sock_connected;
    assign usb_out_data   = f_data;
    assign sock_out_data  = f_data;
    assign f_ready        = sock_connected ? sock_out_ready : usb_out_ready;

    // A full buffer holds the target off before the next character starts
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cts_n_q <= HS_READY_N;
        end else begin
            cts_n_q <= f_in_ready ? HS_READY_N : HS_HOLD_N;
        end
    end

    assign link.cts_n_drv = cts_n_q;
    assign link.cts_n_oe  = drive_cts;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            overrun_q   <= 1'h0;
            frame_err_q <= 1'h0;
        end else begin
            overrun_q   <= rx_valid && en_s2 && !f_in_ready;
            frame_err_q <= rx_ferr && en_s2;
        end
    end
endmodule // sbf_bridge

// >>> hdl/sbf_target.sv
/*
 * Target end with optional flow control and interface enable; two-entry buffer of both ends.
 * Assumes the shifters of the bridge file are compiled alongside.
 */
module sbf_fifo import sbf_pkg::*; #(
    parameter int W     = DATA_BITS,
    parameter int DEPTH = BUF_DEPTH
) (
    input  wire logic                       clock,
    input  wire logic                       rst_n,
    input  wire logic                       in_valid,
    input  wire logic [W-1:0]               in_data,
    output logic                            in_ready,
    output logic                            out_valid,
    output logic [W-1:0]                    out_data,
    input  wire logic                       out_ready,
    output logic [$clog2(DEPTH+1)-1:0]      level
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int LW = $clog2(DEPTH + 1);

    logic [W-1:0]  mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [LW-1:0] cnt_q;
    logic          push;
    logic          pop;

    assign in_ready  = cnt_q != LW'(DEPTH);
    assign out_valid = cnt_q != '0;
    assign out_data  = mem_q[rd_q];
    assign level     = cnt_q;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'h1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'h1;
            end
            cnt_q <= cnt_q + LW'(push) - LW'(pop);
        end
    end
endmodule // sbf_fifo

module sbf_target import sbf_pkg::*; (
    input  wire logic             clock,
    input  wire logic             rst_n,
    sbf_link_if.target            link,
    input  wire logic             cfg_wr,
    input  wire logic             cfg_hs_en,
    input  wire logic [DIV_W-1:0] cfg_bit_cycles,
    input  wire logic             en_wr,
    input  wire logic             en_value,
    input  wire logic             app_tx_valid,
    input  wire logic [7:0]       app_tx_data,
    output logic                  app_tx_ready,
    output logic                  app_rx_valid,
    output logic [7:0]            app_rx_data,
    input  wire logic             app_rx_ready,
    output logic                  overrun_q,
    output logic                  frame_err_q
);
    localparam int LW = $clog2(BUF_DEPTH + 1);

    logic             hs_q, en_q, rts_n_q;
    logic [DIV_W-1:0] div_q;
    logic             rx_s1, rx_s2, cts_s1, cts_s2;
    logic             tx_ready, rx_valid, rx_ferr, f_in_ready;
    logic [7:0]       rx_data;
    logic [LW-1:0]    level;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            hs_q  <= HS_EN_RESET;
            div_q <= DIV_DEFAULT;
        end else if (cfg_wr) begin
            hs_q  <= cfg_hs_en;
            div_q <= sbf_clamp_div(cfg_bit_cycles);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            en_q <= LINK_EN_RESET;
        end else if (en_wr) begin
            en_q <= en_value;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rx_s1  <= LINE_IDLE;
            rx_s2  <= LINE_IDLE;
            cts_s1 <= HS_HOLD_N;
            cts_s2 <= HS_HOLD_N;
        end else begin
            rx_s1  <= link.tgt_rx;
            rx_s2  <= rx_s1;
            cts_s1 <= link.cts_n;
            cts_s2 <= cts_s1;
        end
    end

    assign link.link_en = en_q;
    assign app_tx_ready = tx_ready && (!hs_q || cts_s2 == HS_READY_N);

    sbf_uart_tx u_tx (
        .clock      (clock),
        .rst_n      (rst_n),
        .bit_cycles (div_q),
        .start      (app_tx_valid && app_tx_ready),
        .data       (app_tx_data),
        .ready      (tx_ready),
        .txd_q      (link.tgt_tx)
    );

    sbf_uart_rx u_rx (
        .clock      (clock),
        .rst_n      (rst_n),
        .bit_cycles (div_q),
        .rxd        (rx_s2),
        .valid_q    (rx_valid),
        .ferr_q     (rx_ferr),
        .data_q     (rx_data)
    );

    sbf_fifo #(.W(DATA_BITS), .DEPTH(BUF_DEPTH)) u_buf (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_valid  (rx_valid),
        .in_data   (rx_data),
        .in_ready  (f_in_ready),
        .out_valid (app_rx_valid),
        .out_data  (app_rx_data),
        .out_ready (app_rx_ready),
        .level     (level)
    );

    // Hold off one entry early so the character already in flight still fits
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rts_n_q <= HS_READY_N;
        end else begin
            rts_n_q <= (hs_q && level >= LW'(BUF_DEPTH - 1)) ? HS_HOLD_N : HS_READY_N;
        end
    end

    assign link.rts_n = rts_n_q;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            overrun_q   <= 1'h0;
            frame_err_q <= 1'h0;
        end else begin
            overrun_q   <= rx_valid && !f_in_ready;
            frame_err_q <= rx_ferr;
        end
    end
endmodule // sbf_target

// >>> testbench/sbf_link_chk.sv
/*
 * Checker for the bridge-target link: framing, hold-offs and reset state.
 * Assumes both ends run BIT clocks per bit whenever characters are on the wire.
 */
module sbf_link_chk #(
    parameter int BIT = 54
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic tgt_tx,
    input wire logic tgt_rx,
    input wire logic cts_n_drv,
    input wire logic cts_n_oe,
    input wire logic cts_n,
    input wire logic rts_n,
    input wire logic link_en
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HB   = BIT / 2;
    localparam int STOP = 9 * BIT + HB;
    localparam int CEND = 10 * BIT - 4;
    int rx_cnt_q;
    int tx_cnt_q;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // Position inside a character; ends early so a back-to-back start is caught
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rx_cnt_q <= 0;
        end else if (rx_cnt_q != 0) begin
            rx_cnt_q <= (rx_cnt_q >= CEND) ? 0 : rx_cnt_q + 1;
        end else if ($fell(tgt_rx)) begin
            rx_cnt_q <= 1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tx_cnt_q <= 0;
        end else if (tx_cnt_q != 0) begin
            tx_cnt_q <= (tx_cnt_q >= CEND) ? 0 : tx_cnt_q + 1;
        end else if ($fell(tgt_tx)) begin
            tx_cnt_q <= 1;
        end
    end

    // Sync flops need a few cycles before a hold-off bites
    sequence s_cts_held;
        cts_n [*6] ##0 (tx_cnt_q == 0 && tgt_tx);
    endsequence
    sequence s_en_low;
        (!link_en) [*6] ##0 (rx_cnt_q == 0 && tgt_rx);
    endsequence

    property p_reset_idle;
        $rose(rst_n) |-> tgt_rx && tgt_tx && !cts_n_oe && !cts_n_drv && !rts_n && link_en;
    endproperty
    property p_rx_start;
        rx_cnt_q == HB |-> !tgt_rx;
    endproperty
    property p_rx_stop;
        rx_cnt_q == STOP |-> tgt_rx;
    endproperty
    property p_tx_start;
        tx_cnt_q == HB |-> !tgt_tx;
    endproperty
    property p_tx_stop;
        tx_cnt_q == STOP |-> tgt_tx;
    endproperty
    property p_tgt_hold;
        s_cts_held |=> tgt_tx;
    endproperty
    property p_en_gate;
        s_en_low |=> tgt_rx;
    endproperty
    property p_cts_full;
        $rose(cts_n_drv) |-> tgt_tx && tx_cnt_q >= STOP;
    endproperty
    property p_rts_hold;
        $rose(rts_n) |-> tgt_rx && rx_cnt_q >= STOP;
    endproperty

    a_reset_idle: assert property (p_reset_idle)
        else $error("Link not idle after reset");
    a_rx_start: assert property (p_rx_start)
        else $error("Bridge start bit not low");
    a_rx_stop: assert property (p_rx_stop)
        else $error("Bridge stop bit not high");
    a_tx_start: assert property (p_tx_start)
        else $error("Target start bit not low");
    a_tx_stop: assert property (p_tx_stop)
        else $error("Target stop bit not high");
    a_tgt_hold: assert property (p_tgt_hold)
        else $error("Target sent while held off");
    a_en_gate: assert property (p_en_gate)
        else $error("Bridge sent while link disabled");
    a_cts_full: assert property (p_cts_full)
        else $error("Hold-off raised outside a character end");
    a_rts_hold: assert property (p_rts_hold)
        else $error("Target hold-off raised outside a character end");
endmodule // sbf_link_chk

// >>> testbench/tb_serial_bridge_flow_control.sv
/*
 * Bench joining bridge and target ends; host and target streams checked through queues.
 * Assumes the design files and the link checker are compiled first.
 */
module tb_serial_bridge_flow_control import sbf_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BIT = 54;
    localparam int LIM = 20000;
    logic             clock, rst_n, b_cfg_wr, t_cfg_wr, t_hs_en, en_wr, en_value, sock_connected;
    logic             usb_in_valid, sock_in_valid, usb_out_ready, sock_out_ready, app_tx_valid, app_rx_ready;
    logic             usb_in_ready, sock_in_ready, usb_out_valid, sock_out_valid, app_tx_ready, app_rx_valid;
    logic             b_ovr, b_ferr, t_ovr, t_ferr, drv, gate;
    logic [7:0]       usb_in_data, sock_in_data, app_tx_data, usb_out_data, sock_out_data, app_rx_data;
    logic [DIV_W-1:0] b_div, t_div;
    sbf_hs_mode_t     mode;
    logic [8:0]       exp_h[$];
    logic [7:0]       exp_t[$];
    int               failures, compares, seed;

    sbf_link_if sbf_link_if_inst ();
    sbf_bridge sbf_bridge_inst (.clock, .rst_n, .link(sbf_link_if_inst), .cfg_wr(b_cfg_wr), .cfg_mode(mode),
        .cfg_bit_cycles(b_div), .sock_connected, .usb_in_valid, .usb_in_data, .usb_in_ready, .sock_in_valid,
        .sock_in_data, .sock_in_ready, .usb_out_valid, .usb_out_data, .usb_out_ready, .sock_out_valid,
        .sock_out_data, .sock_out_ready, .overrun_q(b_ovr), .frame_err_q(b_ferr));
    sbf_target sbf_target_inst (.clock, .rst_n, .link(sbf_link_if_inst), .cfg_wr(t_cfg_wr), .cfg_hs_en(t_hs_en),
        .cfg_bit_cycles(t_div), .en_wr, .en_value, .app_tx_valid, .app_tx_data, .app_tx_ready, .app_rx_valid,
        .app_rx_data, .app_rx_ready, .overrun_q(t_ovr), .frame_err_q(t_ferr));
    sbf_link_chk #(.BIT(BIT)) sbf_link_chk_inst (.clock, .rst_n, .tgt_tx(sbf_link_if_inst.tgt_tx),
        .tgt_rx(sbf_link_if_inst.tgt_rx), .cts_n_drv(sbf_link_if_inst.cts_n_drv),
        .cts_n_oe(sbf_link_if_inst.cts_n_oe), .cts_n(sbf_link_if_inst.cts_n),
        .rts_n(sbf_link_if_inst.rts_n), .link_en(sbf_link_if_inst.link_en));

    initial begin
        clock = 1'h0;
        forever #10 clock = ~clock;
    end

    task automatic end_sim;
        $display("Counts: %0d failures in %0d compares", failures, compares);
        if (failures == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tmo;
        failures++;
        $display("Error at %0t: wait ran out", $time);
        end_sim();
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic host_send(input bit s, input logic [7:0] b);
        int n;
        n = 0;
        @(negedge clock);
        exp_t.push_back(b);
        if (s) begin
            sock_in_valid = 1'h1;
            sock_in_data = b;
        end else begin
            usb_in_valid = 1'h1;
            usb_in_data = b;
        end
        #1;
        while ((s ? sock_in_ready : usb_in_ready) !== 1'h1) begin
            if (++n > LIM) tmo();
            @(negedge clock);
            #1;
        end
        @(negedge clock);
        sock_in_valid = 1'h0;
        usb_in_valid = 1'h0;
    endtask

    // Dropped characters leave no note, so any arrival of one is a mismatch
    task automatic tgt_send(input logic [7:0] b, input bit keep);
        int n;
        n = 0;
        @(negedge clock);
        if (keep) exp_h.push_back({sock_connected, b});
        app_tx_valid = 1'h1;
        app_tx_data = b;
        #1;
        while (app_tx_ready !== 1'h1) begin
            if (++n > LIM) tmo();
            @(negedge clock);
            #1;
        end
        @(negedge clock);
        app_tx_valid = 1'h0;
    endtask

    task automatic drain;
        int n;
        n = 0;
        while (exp_t.size() != 0 || exp_h.size() != 0 || app_tx_valid) begin
            if (++n > LIM) tmo();
            @(negedge clock);
        end
        cyc(2 * BIT);
    endtask

    always @(posedge clock) begin
        if (app_rx_valid && app_rx_ready) chk(app_rx_data, exp_t.size() ? exp_t.pop_front() : 'x);
        if (usb_out_valid && usb_out_ready) chk({1'h0, usb_out_data}, exp_h.size() ? exp_h.pop_front() : 'x);
        if (sock_out_valid && sock_out_ready) chk({1'h1, sock_out_data}, exp_h.size() ? exp_h.pop_front() : 'x);
        if (b_ovr || b_ferr || t_ovr || t_ferr) chk(1, 0);
    end

    initial begin
        seed = 32'hd702;
        {rst_n, b_cfg_wr, t_cfg_wr, en_wr, sock_connected, usb_in_valid, sock_in_valid, app_tx_valid} = '0;
        {usb_in_data, sock_in_data, app_tx_data} = '0;
        {t_hs_en, en_value, usb_out_ready, sock_out_ready, app_rx_ready} = '1;
        mode = SBF_HS_DISABLED;
        b_div = 13'h000a;
        t_div = 13'(BIT);
        repeat (3) @(negedge clock);
        rst_n = 1'h1;
        cyc(3);
        chk(sbf_link_if_inst.cts_n_oe, 0);
        chk(sbf_link_if_inst.link_en, 1);
        // Too short a bit time clamps to the fastest rate, which the target runs at
        t_cfg_wr = 1'h1;
        cyc(1);
        t_cfg_wr = 1'h0;
        for (int m = 0; m < 4; m++) begin
            mode = sbf_hs_mode_t'(m);
            drv = (mode == SBF_HS_RTS || mode == SBF_HS_RTSCTS);
            gate = (mode == SBF_HS_CTS || mode == SBF_HS_RTSCTS);
            b_cfg_wr = 1'h1;
            cyc(1);
            b_cfg_wr = 1'h0;
            cyc(2);
            chk(sbf_link_if_inst.cts_n_oe, drv);
            app_rx_ready = 1'h0;
            host_send(0, 8'($random(seed)));
            cyc(12 * BIT);
            chk(sbf_link_if_inst.rts_n, 1);
            chk(usb_in_ready, !gate);
            app_rx_ready = 1'h1;
            usb_out_ready = 1'h0;
            tgt_send(8'($random(seed)), 1);
            tgt_send(8'($random(seed)), 1);
            cyc(12 * BIT);
            chk(sbf_link_if_inst.cts_n, drv);
            if (drv) begin
                fork
                    tgt_send(8'($random(seed)), 1);
                join_none
                cyc(12 * BIT);
                chk(app_tx_ready, 0);
            end
            usb_out_ready = 1'h1;
            drain();
        end
        // Socket takes priority; the refused USB byte must never reach the target
        sock_connected = 1'h1;
        usb_in_valid = 1'h1;
        cyc(2);
        chk(usb_in_ready, 0);
        usb_in_valid = 1'h0;
        host_send(1, 8'($random(seed)));
        tgt_send(8'($random(seed)), 1);
        drain();
        sock_connected = 1'h0;
        en_value = 1'h0;
        en_wr = 1'h1;
        cyc(1);
        en_wr = 1'h0;
        cyc(4);
        chk(sbf_link_if_inst.link_en, 0);
        tgt_send(8'($random(seed)), 0);
        usb_in_valid = 1'h1;
        cyc(12 * BIT);
        chk(usb_in_ready, 0);
        usb_in_valid = 1'h0;
        en_value = 1'h1;
        en_wr = 1'h1;
        cyc(1);
        en_wr = 1'h0;
        cyc(4);
        fork
            repeat (4) tgt_send(8'($random(seed)), 1);
        join_none
        repeat (4) host_send(0, 8'($random(seed)));
        drain();
        end_sim();
    end
endmodule // tb_serial_bridge_flow_control
